// ### design/bcpm_cfg.svh
/*
 * Offsets, field positions, reset values and fixed codes of the
 * bridge configuration and power-management register group.
 * Assumes word addressing by byte offset on an 8-bit address port.
 */
`ifndef BCPM_CFG_SVH
`define BCPM_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define BCPM_OFF_IRQ_BRIDGE   8'h3C
`define BCPM_OFF_SUBSYS_ID    8'h40
`define BCPM_OFF_LEGACY_BASE  8'h44
`define BCPM_OFF_PM_CAP       8'h80
`define BCPM_OFF_PM_CSR       8'h84
`define BCPM_OFF_MISC_CTL     8'h98

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BCPM_BIT_PARITY_EN    16
`define BCPM_BIT_SERR_EN      17
`define BCPM_BIT_ABORT_MODE   21
`define BCPM_BIT_CARD_RESET   22
`define BCPM_BIT_IRQ_ROUTE    23
`define BCPM_BIT_POST_EN      26
`define BCPM_BIT_WAKE_EN      8
`define BCPM_BIT_WAKE_STAT    15
`define BCPM_BIT_SUBSYS_LOCK  0

// ----------------------------------------------------------------------
// Reset values and fixed codes
// ----------------------------------------------------------------------
`define BCPM_PIN_FUNC_A       8'h01
`define BCPM_PIN_FUNC_B       8'h02
`define BCPM_PM_CAP_VALUE     32'hFE110001
`define BCPM_LEGACY_IO_TAG    2'h1
`define BCPM_ALL_ONES         32'hFFFFFFFF

`endif

// ### design/bcpm_pkg.sv
/*
 * Types shared by the bridge configuration register group.
 * Assumes the configuration header is included alongside.
 */
package bcpm_pkg;
	// Power state of the socket interface
	typedef enum logic [1:0] {
		BCPM_D0,
		BCPM_D1,
		BCPM_D2,
		BCPM_D3
	} bcpm_pstate_t;

	// Posting sequencer for socket writes
	typedef enum logic [1:0] {
		BCPM_W_IDLE,
		BCPM_W_DRAIN,
		BCPM_W_PASS
	} bcpm_wstate_t;
endpackage : bcpm_pkg

// ### design/bcpm_regs.sv
/*
 * Per-socket bridge control, subsystem identity, legacy I/O base and
 * power-management registers of a PCI-to-card bridge function.
 * Assumes a simple register port (read data one cycle after the strobe)
 * and card-side event inputs arriving from another clock domain.
 */
// The implementer's own choice: the strobed register port.
// Operation
// - Interrupt line byte is stored for software only, reset zero.
// - Interrupt pin byte reads first line for socket A, second for B.
// - Parity response bit gates card parity error detection; reset zero.
// - Card system errors forwarded to host only while forwarding bit set.
// - Master abort: all ones and drop writes, or target abort/system error.
// - Card reset bit drives socket reset low; resets to one.
// - Host reset also resets card; forced reset clears card-side registers.
// - Socket reset never resets host-side registers.
// - Card interrupts go to legacy IRQ or PCI pin per routing bit in legacy IRQ mode; PCI pin otherwise.
// - Ring indicate moves both socket interrupts onto first PCI line.
// - Posting off: drain, pass word by word, hold master until last.
// - Prefetch, legacy-bus, video and reserved bits read zero.
// - Software loads subsystem IDs; lock bit makes them read-only.
// - Legacy base reads low bits 01 with writable upper base.
// - Operation registers decode through I/O only with nonzero base.
// - Capability header read-only, next pointer zero, revision 001.
// - Capability bits advertise D1, D2, wake from all states, aux power.
// - Two-bit power state field, D0 to D3.
// - Wake enable lets wake events show on the event pin.
// - Wake status sets on any wake event; write one clears.
// - Data select, scale and bits 23:16 of control read zero.
// - Card-side system error only for address parity errors.
`timescale 1ns/1ps
`include "bcpm_cfg.svh"

module bcpm_regs
	import bcpm_pkg::*;
#(
	parameter bit SOCKET_B = 1'b0
) (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        clk_en,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        ring_enable,
	input  wire logic        legacy_irq_mode,
	input  wire logic        card_addr_perr,
	input  wire logic        card_data_perr,
	input  wire logic        card_irq_request,
	input  wire logic        wake_event,
	input  wire logic        master_abort,
	input  wire logic        master_is_read,
	input  wire logic        target_abort_ok,
	input  wire logic        sock_wr_req,
	input  wire logic        buffers_empty,
	input  wire logic        target_ack,
	input  wire logic        sock_wr_last,
	output logic             socket_reset_out_n,
	output logic             card_serr,
	output logic             host_serr,
	output logic             parity_err_seen,
	output logic             abort_force_ones,
	output logic             abort_target,
	output logic             irq_to_legacy,
	output logic             irq_to_pci_a,
	output logic             irq_to_pci_b,
	output logic             sock_wr_accept,
	output logic             source_hold,
	output logic             io_decode_en,
	output logic             wake_pin_n,
	output logic [1:0]       power_state
);

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic [6:0] sync_a;
	logic [6:0] sync_b;
	wire  [6:0] raw_in = {sock_wr_last, target_ack, buffers_empty, wake_event,
	                      card_irq_request, card_data_perr, card_addr_perr};

	// Two flops on the card event and socket handshake inputs; the abort inputs enter unsynchronised
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			sync_a <= 7'h00;
			sync_b <= 7'h00;
		end else if (clk_en) begin
			sync_a <= raw_in;
			sync_b <= sync_a;
		end
	end

	wire s_aperr  = sync_b[0];
	wire s_dperr  = sync_b[1];
	wire s_irq    = sync_b[2];
	wire s_wake   = sync_b[3];
	wire s_empty  = sync_b[4];
	wire s_ack    = sync_b[5];
	wire s_last   = sync_b[6];

	// ------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------
	logic [7:0]   irq_line;
	logic         parity_en;
	logic         serr_en;
	logic         abort_mode;
	logic         card_reset;
	logic         irq_route;
	logic         post_en;
	logic [31:0]  subsys_id;
	logic         subsys_lock;
	logic [29:0]  legacy_base;
	bcpm_pstate_t pstate;
	logic         wake_en;
	logic         wake_stat;
	bcpm_wstate_t wstate;

	// Write decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	wire wr_bridge = reg_wr && hit(reg_addr, `BCPM_OFF_IRQ_BRIDGE);
	wire wr_subsys = reg_wr && hit(reg_addr, `BCPM_OFF_SUBSYS_ID) && !subsys_lock;
	wire wr_legacy = reg_wr && hit(reg_addr, `BCPM_OFF_LEGACY_BASE);
	wire wr_pmcsr  = reg_wr && hit(reg_addr, `BCPM_OFF_PM_CSR);
	wire wr_misc   = reg_wr && hit(reg_addr, `BCPM_OFF_MISC_CTL);

	// Host-side bridge control; only the primary reset touches these
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_line   <= 8'h00;
			parity_en  <= 1'b0;
			serr_en    <= 1'b0;
			abort_mode <= 1'b0;
			card_reset <= 1'b1;
			irq_route  <= 1'b0;
			post_en    <= 1'b0;
		end else if (clk_en && wr_bridge) begin
			irq_line   <= reg_wdata[7:0];
			parity_en  <= reg_wdata[`BCPM_BIT_PARITY_EN];
			serr_en    <= reg_wdata[`BCPM_BIT_SERR_EN];
			abort_mode <= reg_wdata[`BCPM_BIT_ABORT_MODE];
			card_reset <= reg_wdata[`BCPM_BIT_CARD_RESET];
			irq_route  <= reg_wdata[`BCPM_BIT_IRQ_ROUTE];
			post_en    <= reg_wdata[`BCPM_BIT_POST_EN];
		end
	end

	// Identity, lock and legacy base; socket reset does not reach them
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			subsys_id   <= 32'h00000000;
			subsys_lock <= 1'b0;
			legacy_base <= 30'h00000000;
		end else if (clk_en) begin
			if (wr_subsys)
				subsys_id <= reg_wdata;
			if (wr_misc)
				subsys_lock <= reg_wdata[`BCPM_BIT_SUBSYS_LOCK];
			if (wr_legacy)
				legacy_base <= reg_wdata[31:2];
		end
	end

	// Power state and wake bits; set wins over a same-cycle clear
	wire clr_wake = wr_pmcsr && reg_wdata[`BCPM_BIT_WAKE_STAT];
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pstate    <= BCPM_D0;
			wake_en   <= 1'b0;
			wake_stat <= 1'b0;
		end else if (clk_en) begin
			if (wr_pmcsr) begin
				pstate  <= bcpm_pstate_t'(reg_wdata[1:0]);
				wake_en <= reg_wdata[`BCPM_BIT_WAKE_EN];
			end
			if (s_wake)
				wake_stat <= 1'b1;
			else if (clr_wake)
				wake_stat <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------------
	wire [7:0]  pin_code = SOCKET_B ? `BCPM_PIN_FUNC_B : `BCPM_PIN_FUNC_A;
	// Unimplemented bridge bits stay zero
	wire [31:0] rd_bridge = {5'h00, post_en, 2'h0, irq_route, card_reset, abort_mode,
	                         3'h0, serr_en, parity_en, pin_code, irq_line};
	// Data select, scale and 23:16 stay zero
	wire [31:0] rd_pmcsr  = {16'h0000, wake_stat, 6'h00, wake_en, 6'h00,
	                         pstate};
	wire [31:0] rd_legacy = {legacy_base, `BCPM_LEGACY_IO_TAG};
	wire [31:0] rd_misc   = {31'h00000000, subsys_lock};
	wire [31:0] rd_mux =
		hit(reg_addr, `BCPM_OFF_IRQ_BRIDGE)  ? rd_bridge :
		hit(reg_addr, `BCPM_OFF_SUBSYS_ID)   ? subsys_id :
		hit(reg_addr, `BCPM_OFF_LEGACY_BASE) ? rd_legacy :
		hit(reg_addr, `BCPM_OFF_PM_CAP)      ? `BCPM_PM_CAP_VALUE :
		hit(reg_addr, `BCPM_OFF_PM_CSR)      ? rd_pmcsr :
		hit(reg_addr, `BCPM_OFF_MISC_CTL)    ? rd_misc : 32'h00000000;

	// Read data stands one cycle after the strobe, zero otherwise
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			reg_rdata <= 32'h00000000;
		else if (clk_en)
			reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
	end

	// ------------------------------------------------------------------
	// Socket write sequencer
	// ------------------------------------------------------------------
	bcpm_wstate_t next_wstate;
	always_comb begin
		next_wstate = wstate;
		case (wstate)
			BCPM_W_IDLE:  if (sock_wr_req && !post_en) next_wstate = BCPM_W_DRAIN;
			BCPM_W_DRAIN: if (s_empty) next_wstate = BCPM_W_PASS;
			BCPM_W_PASS:  if (s_ack && s_last) next_wstate = BCPM_W_IDLE;
			default:      next_wstate = BCPM_W_IDLE;
		endcase
	end

	// Sequencer state
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			wstate <= BCPM_W_IDLE;
		else if (clk_en)
			wstate <= next_wstate;
	end

	// ------------------------------------------------------------------
	// Derived outputs
	// ------------------------------------------------------------------
	wire next_cserr   = parity_en && s_aperr;
	wire next_perr    = parity_en && (s_aperr || s_dperr);
	wire next_hserr   = serr_en && (next_cserr ||
	                    (master_abort && abort_mode && !target_abort_ok));
	wire next_ones    = master_abort && !abort_mode && master_is_read;
	wire next_tabort  = master_abort && abort_mode && target_abort_ok;
	wire next_legacy  = legacy_irq_mode && irq_route && s_irq;
	wire pci_irq      = s_irq && !(legacy_irq_mode && irq_route);
	wire next_pci_a   = pci_irq && (!SOCKET_B || ring_enable);
	wire next_pci_b   = pci_irq && SOCKET_B && !ring_enable;
	wire next_accept  = post_en ? sock_wr_req :
	                    (next_wstate == BCPM_W_PASS) && s_ack;
	wire next_hold    = !post_en && (next_wstate != BCPM_W_IDLE);
	wire next_iodec   = (legacy_base != 30'h00000000);
	wire next_wake_n  = !(wake_stat && wake_en);

	// Registered outputs
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			socket_reset_out_n <= 1'b0;
			card_serr          <= 1'b0;
			host_serr          <= 1'b0;
			parity_err_seen    <= 1'b0;
			abort_force_ones   <= 1'b0;
			abort_target       <= 1'b0;
			irq_to_legacy      <= 1'b0;
			irq_to_pci_a       <= 1'b0;
			irq_to_pci_b       <= 1'b0;
			sock_wr_accept     <= 1'b0;
			source_hold        <= 1'b0;
			io_decode_en       <= 1'b0;
			wake_pin_n         <= 1'b1;
			power_state        <= 2'h0;
		end else if (clk_en) begin
			socket_reset_out_n <= !card_reset;
			card_serr          <= next_cserr;
			host_serr          <= next_hserr;
			parity_err_seen    <= next_perr;
			abort_force_ones   <= next_ones;
			abort_target       <= next_tabort;
			irq_to_legacy      <= next_legacy;
			irq_to_pci_a       <= next_pci_a;
			irq_to_pci_b       <= next_pci_b;
			sock_wr_accept     <= next_accept;
			source_hold        <= next_hold;
			io_decode_en       <= next_iodec;
			wake_pin_n         <= next_wake_n;
			power_state        <= pstate;
		end
	end

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	reset_pin_track_a: assert property (clk_en && wr_bridge ##1 clk_en |=>
		socket_reset_out_n == !$past(reg_wdata[`BCPM_BIT_CARD_RESET], 2))
		else $error("socket reset does not follow control bit");
	wake_pin_a: assert property (clk_en |=>
		wake_pin_n == !($past(wake_stat) && $past(wake_en)))
		else $error("wake pin mismatch");
	wake_sticky_a: assert property (clk_en && s_wake |=> wake_stat)
		else $error("wake status not set");
	wake_w0_a: assert property (clk_en && wake_stat && !clr_wake |=> wake_stat)
		else $error("wake status lost without write one");
	lock_id_a: assert property (subsys_lock && !wr_misc |=> $stable(subsys_id))
		else $error("locked identity changed");
	cap_read_a: assert property (reg_rd && clk_en && hit(reg_addr, `BCPM_OFF_PM_CAP) |=>
		reg_rdata == `BCPM_PM_CAP_VALUE)
		else $error("capability header wrong");
	legacy_tag_a: assert property (reg_rd && clk_en && hit(reg_addr, `BCPM_OFF_LEGACY_BASE)
		|=> reg_rdata[1:0] == 2'h1)
		else $error("legacy base tag wrong");
	serr_gate_a: assert property (!serr_en && clk_en |=> !host_serr)
		else $error("system error forwarded while disabled");
	card_serr_a: assert property (card_serr |-> $past(s_aperr))
		else $error("card system error without address parity");
	pmcsr_zero_a: assert property (reg_rd && clk_en && hit(reg_addr, `BCPM_OFF_PM_CSR) |=>
		reg_rdata[31:16] == 16'h0000 && reg_rdata[14:9] == 6'h00)
		else $error("power control zero fields nonzero");

	wake_seen_c:   cover property (wake_stat && wake_en ##1 !wake_pin_n);
	lock_write_c:  cover property (subsys_lock && reg_wr && hit(reg_addr, `BCPM_OFF_SUBSYS_ID));
	drain_pass_c:  cover property (wstate == BCPM_W_DRAIN ##[1:8] wstate == BCPM_W_PASS);
	abort_ones_c:  cover property (abort_force_ones);

endmodule : bcpm_regs

// ### tb/bcpm_regs_tb.sv
/*
 * Self-checking bench for the bridge configuration register block.
 * Assumes the socket model sits on the write-posting handshake.
 */
`timescale 1ns/1ps
`include "bcpm_cfg.svh"

`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin fails++; \
	$display("CHECK FAILED %s exp=%0h got=%0h", nm, e, g); end end

module bcpm_regs_tb;
	import bcpm_pkg::*;

	logic        core_clk = 0, rst = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
	logic        ring_enable = 0, legacy_irq_mode = 0, card_addr_perr = 0, card_data_perr = 0;
	logic        card_irq_request = 0, wake_event = 0, master_abort = 0, master_is_read = 0;
	logic        target_abort_ok = 0, sock_wr_req = 0, drained = 0;
	logic        buffers_empty, target_ack, sock_wr_last, socket_reset_out_n, card_serr;
	logic        host_serr, parity_err_seen, abort_force_ones, abort_target, irq_to_legacy;
	logic        irq_to_pci_a, irq_to_pci_b, sock_wr_accept, source_hold, io_decode_en;
	logic        wake_pin_n;
	logic [1:0]  power_state;
	logic [10:0] hits;
	int          fails = 0, checks = 0;

	always #20 core_clk = ~core_clk;

	bcpm_regs #(.SOCKET_B(1'b0)) u_dut (.core_clk(core_clk), .rst(rst), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ring_enable(ring_enable), .legacy_irq_mode(legacy_irq_mode),
		.card_addr_perr(card_addr_perr), .card_data_perr(card_data_perr),
		.card_irq_request(card_irq_request), .wake_event(wake_event),
		.master_abort(master_abort), .master_is_read(master_is_read),
		.target_abort_ok(target_abort_ok), .sock_wr_req(sock_wr_req),
		.buffers_empty(buffers_empty), .target_ack(target_ack), .sock_wr_last(sock_wr_last),
		.socket_reset_out_n(socket_reset_out_n), .card_serr(card_serr), .host_serr(host_serr),
		.parity_err_seen(parity_err_seen), .abort_force_ones(abort_force_ones),
		.abort_target(abort_target), .irq_to_legacy(irq_to_legacy),
		.irq_to_pci_a(irq_to_pci_a), .irq_to_pci_b(irq_to_pci_b),
		.sock_wr_accept(sock_wr_accept), .source_hold(source_hold),
		.io_decode_en(io_decode_en), .wake_pin_n(wake_pin_n), .power_state(power_state));

	bcpm_sock_model u_sock (.core_clk(core_clk), .rst(rst), .sock_wr_accept(sock_wr_accept),
		.drained(drained), .ack_delay(4'h2), .words(4'h3), .buffers_empty(buffers_empty),
		.target_ack(target_ack), .sock_wr_last(sock_wr_last));

	// ----------------------------------------------------------------------
	// Output activity capture
	// ----------------------------------------------------------------------
	// Sticky record of which outputs went active inside an observation window
	always @(posedge core_clk) begin
		hits = hits | {~wake_pin_n, source_hold, sock_wr_accept, irq_to_pci_b, irq_to_pci_a,
			irq_to_legacy, abort_target, abort_force_ones, parity_err_seen, host_serr, card_serr};
	end

	// ----------------------------------------------------------------------
	// Register port tasks
	// ----------------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr    <= 1'b0;
	endtask : wr

	// Read data stands only in the cycle after the strobe
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd   <= 1'b0;
		#1 rd = reg_rdata;
		`CHK("reg_rdata", e, rd)
	endtask : rdchk

	// Let earlier effects settle, then watch outputs for n cycles
	task automatic window(input int pre, input int n);
		repeat (pre) @(posedge core_clk);
		#1 hits = '0;
		repeat (n) @(posedge core_clk);
		#1;
	endtask : window

	task automatic finish_test;
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test

	// Bounds the whole run
	initial begin
		#(40 * 20000);
		fails++;
		finish_test();
	end

	// ----------------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------------
	initial begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		`CHK("sock_rst_n", 1'b0, socket_reset_out_n)
		rdchk(`BCPM_OFF_IRQ_BRIDGE, 32'h00400100);
		rdchk(`BCPM_OFF_LEGACY_BASE, 32'h00000001);
		rdchk(`BCPM_OFF_PM_CAP, `BCPM_PM_CAP_VALUE);
		rdchk(`BCPM_OFF_PM_CSR, 32'h00000000);
		rdchk(8'h10, 32'h00000000);
		wr(`BCPM_OFF_IRQ_BRIDGE, 32'hFFFFFFFF);
		rdchk(`BCPM_OFF_IRQ_BRIDGE, 32'h04E301FF);
		`CHK("sock_rst_n", 1'b0, socket_reset_out_n)
		// Identity words lock against later writes and survive card reset
		wr(`BCPM_OFF_SUBSYS_ID, 32'h12345678);
		wr(`BCPM_OFF_MISC_CTL, 32'h00000001);
		wr(`BCPM_OFF_SUBSYS_ID, 32'h00000000);
		wr(`BCPM_OFF_IRQ_BRIDGE, 32'h04A30055);
		rdchk(`BCPM_OFF_SUBSYS_ID, 32'h12345678);
		`CHK("sock_rst_n", 1'b1, socket_reset_out_n)
		rdchk(`BCPM_OFF_IRQ_BRIDGE, 32'h04A30155);
		// Parity and system error gating
		wr(`BCPM_OFF_IRQ_BRIDGE, 32'h04000055);
		card_addr_perr <= 1'b1;
		window(0, 8);
		`CHK("perr_off", 3'b000, hits[2:0])
		wr(`BCPM_OFF_IRQ_BRIDGE, 32'h04A30055);
		window(2, 6);
		`CHK("perr_on", 3'b111, hits[2:0])
		card_addr_perr <= 1'b0;
		card_data_perr <= 1'b1;
		window(5, 6);
		`CHK("data_perr", 3'b100, hits[2:0])
		card_data_perr  <= 1'b0;
		// Master abort in both modes
		target_abort_ok <= 1'b1;
		master_is_read  <= 1'b1;
		for (int m = 1; m >= 0; m--) begin
			wr(`BCPM_OFF_IRQ_BRIDGE, m ? 32'h04230055 : 32'h04030055);
			window(4, 0);
			master_abort <= 1'b1;
			@(posedge core_clk);
			master_abort <= 1'b0;
			window(0, 4);
			`CHK("abort", m ? 2'b10 : 2'b01, hits[4:3])
		end
		// Card interrupt routing in non-PCI signalling mode
		legacy_irq_mode  <= 1'b1;
		card_irq_request <= 1'b1;
		window(4, 4);
		`CHK("irq_pin", 3'b010, hits[7:5])
		wr(`BCPM_OFF_IRQ_BRIDGE, 32'h04830055);
		window(4, 4);
		`CHK("irq_legacy", 3'b001, hits[7:5])
		// Write posting on, then off with drain and word pacing
		sock_wr_req <= 1'b1;
		window(0, 6);
		`CHK("post_on", 1'b1, hits[8])
		wr(`BCPM_OFF_IRQ_BRIDGE, 32'h00830055);
		window(6, 8);
		`CHK("post_drain", 2'b10, hits[9:8])
		drained <= 1'b1;
		window(0, 20);
		`CHK("post_pass", 2'b11, hits[9:8])
		sock_wr_req <= 1'b0;
		window(8, 4);
		`CHK("post_release", 1'b0, hits[9])
		// Power state field, fixed-zero bits, wake status and enable
		wr(`BCPM_OFF_PM_CSR, 32'hFFFFFFFF);
		rdchk(`BCPM_OFF_PM_CSR, 32'h00000103);
		for (int s = 0; s < 4; s++) begin
			wr(`BCPM_OFF_PM_CSR, 32'(s));
			rdchk(`BCPM_OFF_PM_CSR, 32'(s));
			`CHK("power_state", 2'(s), power_state)
		end
		wake_event <= 1'b1;
		@(posedge core_clk);
		wake_event <= 1'b0;
		window(0, 6);
		`CHK("wake_off", 1'b0, hits[10])
		rdchk(`BCPM_OFF_PM_CSR, 32'h00008003);
		wr(`BCPM_OFF_PM_CSR, 32'h00000103);
		window(3, 0);
		`CHK("wake_pin", 1'b0, wake_pin_n)
		rdchk(`BCPM_OFF_PM_CSR, 32'h00008103);
		wr(`BCPM_OFF_PM_CSR, 32'h00008103);
		rdchk(`BCPM_OFF_PM_CSR, 32'h00000103);
		window(3, 0);
		`CHK("wake_pin", 1'b1, wake_pin_n)
		// Legacy base, decode enable and read-only capability word
		wr(`BCPM_OFF_LEGACY_BASE, 32'h000003E0);
		rdchk(`BCPM_OFF_LEGACY_BASE, 32'h000003E1);
		`CHK("io_decode_en", 1'b1, io_decode_en)
		wr(`BCPM_OFF_PM_CAP, 32'h00000000);
		rdchk(`BCPM_OFF_PM_CAP, 32'hFE110001);
		finish_test();
	end
endmodule : bcpm_regs_tb

// ### tb/bcpm_sock_model.sv
/*
 * Behavioural socket-side write target for the bridge register block.
 * Assumes the bench chooses drain state, acknowledge delay and burst length.
 */
`timescale 1ns/1ps

module bcpm_sock_model (
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       sock_wr_accept,
	input  wire logic       drained,
	input  wire logic [3:0] ack_delay,
	input  wire logic [3:0] words,
	output logic            buffers_empty,
	output logic            target_ack,
	output logic            sock_wr_last
);
	logic [3:0] busy_cnt;
	logic [3:0] taken;

	// ----------------------------------------------------------------------
	// Target pacing
	// ----------------------------------------------------------------------
	// Each word accepted while drained keeps the target busy for a programmable time
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			busy_cnt <= 4'h0;
			taken    <= 4'h0;
		end else if (!drained) begin
			taken    <= 4'h0;
		end else if (sock_wr_accept) begin
			busy_cnt <= ack_delay;
			taken    <= (taken == 4'hF) ? taken : taken + 4'h1; // Saturate, no wrap
		end else if (busy_cnt != 4'h0) begin
			busy_cnt <= busy_cnt - 4'h1;
		end
	end

	// Ready only once drained and idle; last flag marks the final word
	assign buffers_empty = drained;
	assign target_ack    = drained && (busy_cnt == 4'h0);
	assign sock_wr_last  = drained && (taken >= words - 4'h1);
endmodule : bcpm_sock_model
